// ---- rtl/afh_regs.vh ----
// Register map, field positions, reset values and codes of the audio frame header framer
// Operation
// - Transport frame: two header octets, then payload
// - Header octet one: MSB zero, seven-bit kind
// - Slot index 0..3 in top two bits
// - Rate index low five bits, bit six zero
// - Kinds 0..13: rate index zero, 20 ms
// - Kind 14 marks lost audio
// - Kind 15 empty, duration from rate index
// - Undefined kind: discard frame, flag erased
// - Silence suppression only with kinds 0..8
// - Payload from octet three, MSB first
// - Payload count fixed by frame kind
// - Storage header: top three bits zero
// - Storage superframe for kinds 10..13, 16..47
// - Superframe payload is four frame counts
// - Kind and rate change at superframe bounds
// - Storage unit duration derived from rate
// - Kinds 16..47 core/stereo, 48..127 reserved
// - Rate indices 1..13 map 12800..38400 Hz
`ifndef AFH_REGS_VH
`define AFH_REGS_VH
// ==========================================================
// Register byte offsets
`define AFH_OFS_CTRL 8'h00
`define AFH_OFS_TX_HDR 8'h04
`define AFH_OFS_TX_GO 8'h08
`define AFH_OFS_STATUS 8'h0c
`define AFH_OFS_RX_HDR 8'h10
`define AFH_OFS_RX_DUR 8'h14
`define AFH_OFS_TX_SLOT 8'h18
// ==========================================================
// Field positions
`define AFH_CTRL_STORAGE 0
`define AFH_CTRL_SILENCE 1
`define AFH_HDR_KIND_LSB 0
`define AFH_HDR_RATE_LSB 8
`define AFH_RXH_SLOT_LSB 8
`define AFH_RXH_RATE_LSB 16
`define AFH_ST_BUSY 0
`define AFH_ST_ERASED 1
`define AFH_ST_LOST 2
`define AFH_ST_CFGERR 3
`define AFH_ST_RXEMPTY 4
// ==========================================================
// Reset values
`define AFH_CTRL_RST 2'h0
`define AFH_TX_HDR_RST 13'h0000
// ==========================================================
// Frame kind codes and limits
`define AFH_KIND_LOST 7'h0e
`define AFH_KIND_EMPTY 7'h0f
`define AFH_KIND_LEG_LAST 7'h0d
`define AFH_KIND_SIL_LAST 7'h08
`define AFH_KIND_RESVD 7'h30
`define AFH_SUPER_FRAMES 3'h4
`define AFH_SLOT_LAST 2'h3
// AXI responses
`define AFH_RESP_OKAY 2'h0
`define AFH_RESP_DECERR 2'h3
`endif

// ---- rtl/afh_kind_info.v ----
// Frame kind decoder: payload octet count, superframe use and validity
`include "afh_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module afh_kind_info #(
  parameter [127:0] LEGACY_LEN = 128'h0 // Octets per legacy kind 0..15, 8 bits each
) (
  input wire [6:0] kind,
  input wire storage,
  output reg [8:0] len,
  output reg is_super,
  output reg valid
);
  reg [7:0] per_frame; // Octets of one frame
  // ==========================================================
  // Per-frame octet table
  always @*
  begin
    per_frame = 8'h00;
    valid = 1'b1;
    if (kind < 7'h10)
      per_frame = LEGACY_LEN[{kind[3:0], 3'h0} +: 8];
    else
    begin
      case (kind)
        7'h10: per_frame = 8'd26;
        7'h11: per_frame = 8'd30;
        7'h12: per_frame = 8'd34;
        7'h13, 7'h1c: per_frame = 8'd38;
        7'h14: per_frame = 8'd42;
        7'h15, 7'h22: per_frame = 8'd48;
        7'h16: per_frame = 8'd52;
        7'h17, 7'h28: per_frame = 8'd60;
        7'h18: per_frame = 8'd31;
        7'h19: per_frame = 8'd32;
        7'h1a: per_frame = 8'd35;
        7'h1b: per_frame = 8'd36;
        7'h1d: per_frame = 8'd40;
        7'h1e: per_frame = 8'd41;
        7'h1f: per_frame = 8'd43;
        7'h20: per_frame = 8'd45;
        7'h21: per_frame = 8'd46;
        7'h23: per_frame = 8'd50;
        7'h24: per_frame = 8'd51;
        7'h25: per_frame = 8'd53;
        7'h26: per_frame = 8'd56;
        7'h27: per_frame = 8'd58;
        7'h29: per_frame = 8'd64;
        7'h2a: per_frame = 8'd65;
        7'h2b: per_frame = 8'd67;
        7'h2c: per_frame = 8'd72;
        7'h2d: per_frame = 8'd74;
        7'h2e: per_frame = 8'd75;
        7'h2f: per_frame = 8'd80;
        default: valid = 1'b0; // Reserved kinds
      endcase
    end
    // Superframe kinds: 10..13 and 16..47
    is_super = ((kind >= 7'h0a) && (kind <= 7'h0d)) ||
               ((kind >= 7'h10) && (kind < `AFH_KIND_RESVD));
    // Storage superframe carries four frames; legacy lengths must stay below 128
    if (storage && is_super)
      len = {per_frame[6:0], 2'b00};
    else
      len = {1'b0, per_frame};
  end
endmodule
`default_nettype wire

// ---- rtl/afh_rate_info.v ----
// Rate index decoder: unit duration in 10 us steps
`timescale 1ns/1ps
`default_nettype none
module afh_rate_info (
  input wire [4:0] rate,
  input wire legacy,
  input wire storage,
  output reg [15:0] dur
);
  // ==========================================================
  // Superframe duration is 80 ms scaled by 25600 Hz over rate
  always @*
  begin
    case (rate)
      5'd1: dur = 16'd16000;
      5'd2: dur = 16'd14222;
      5'd3: dur = 16'd12800;
      5'd4: dur = 16'd12000;
      5'd5: dur = 16'd10667;
      5'd6: dur = 16'd9600;
      5'd7: dur = 16'd8533;
      5'd8: dur = 16'd8000;
      5'd9: dur = 16'd7111;
      5'd10: dur = 16'd6400;
      5'd11: dur = 16'd6000;
      5'd12: dur = 16'd5689;
      5'd13: dur = 16'd5333;
      default: dur = 16'd8000;
    endcase
    // Legacy kinds always last one 20 ms frame
    if (legacy || rate == 5'd0)
      dur = 16'd2000;
    else if (!storage)
      dur = {2'b00, dur[15:2]}; // One frame is a quarter superframe
  end
endmodule
`default_nettype wire

// ---- rtl/afh_framer.v ----
// Audio frame header framer and parser with AXI4-Lite control
`include "afh_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module afh_framer #(
  parameter [127:0] LEGACY_LEN = 128'h0 // Octets per legacy kind 0..15
) (
  input wire sys_clk,
  input wire resetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] tx_pay_data,
  input wire tx_pay_valid,
  output reg tx_pay_ready,
  output reg [7:0] tx_out_data,
  output reg tx_out_valid,
  input wire tx_out_ready,
  output reg tx_out_last,
  input wire [7:0] rx_in_data,
  input wire rx_in_valid,
  output reg rx_in_ready,
  input wire rx_in_last,
  output reg [7:0] rx_pay_data,
  output reg rx_pay_valid,
  input wire rx_pay_ready,
  output reg rx_pay_last
);
  // ==========================================================
  // States
  localparam [1:0] ST_IDLE = 2'd0; // Framer waiting / parser at header one
  localparam [1:0] ST_HDR2 = 2'd1; // Second header octet
  localparam [1:0] ST_PAY = 2'd2; // Payload octets
  localparam [1:0] ST_DROP = 2'd3; // Parser discarding

  reg rst_meta_r; // Reset synchroniser stage one
  reg rst_n_r; // Synchronised reset
  reg [1:0] ctrl_r; // Storage mode and silence suppression
  reg [12:0] tx_hdr_r; // Requested kind and rate index
  reg [4:0] status_r; // Busy plus sticky flags
  reg aw_have_r; // Write address held
  reg w_have_r; // Write data held
  reg [7:0] aw_addr_r; // Held write address
  reg [31:0] w_data_r; // Held write data
  reg [3:0] w_strb_r; // Held byte strobes
  reg go_r; // Framer start pulse
  reg [4:0] sticky_set; // Hardware set requests
  reg [4:0] sticky_clr; // Software clear requests
  // Framer state
  reg [1:0] tx_st_r;
  reg [8:0] tx_rem_r; // Payload octets left
  reg [1:0] slot_r; // Superframe slot index
  reg [6:0] sf_kind_r; // Kind held over a superframe
  reg [4:0] sf_rate_r; // Rate held over a superframe
  reg [7:0] tx_hdr2_r; // Second header octet to send
  reg tx_super_r; // Unit belongs to a superframe
  // Parser state
  reg [1:0] rx_st_r;
  reg [6:0] rx_kind_r; // Received kind
  reg [1:0] rx_slot_r; // Received slot index
  reg [4:0] rx_rate_r; // Received rate index
  reg rx_bad_r; // Header one was malformed
  reg [8:0] rx_rem_r; // Payload octets left

  wire [6:0] tx_kind; // Kind used for this unit
  wire [4:0] tx_rate; // Rate used for this unit
  wire [8:0] tx_len;
  wire tx_super;
  wire tx_kvalid;
  wire [8:0] rx_len;
  wire rx_kvalid;
  wire [15:0] rx_dur;
  wire wr_fire; // Register write happens
  wire tx_out_fire; // Output octet taken
  wire rx_in_fire; // Input octet taken
  wire rx_pay_fire; // Parsed octet taken
  wire [6:0] rx_kind_now; // Kind seen in header one

  // ==========================================================
  // Reset release through two flip-flops
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ==========================================================
  // Kind and rate decoders
  // Within a superframe the first slot's kind and rate stay in force
  assign tx_kind = (slot_r != 2'd0) ? sf_kind_r : tx_hdr_r[6:0];
  assign tx_rate = (slot_r != 2'd0) ? sf_rate_r : tx_hdr_r[12:8];
  assign rx_kind_now = rx_in_data[6:0];

  afh_kind_info #(.LEGACY_LEN(LEGACY_LEN)) u_tx_kind (
    .kind(tx_kind),
    .storage(ctrl_r[`AFH_CTRL_STORAGE]),
    .len(tx_len),
    .is_super(tx_super),
    .valid(tx_kvalid)
  );

  afh_kind_info #(.LEGACY_LEN(LEGACY_LEN)) u_rx_kind (
    .kind(rx_kind_r),
    .storage(ctrl_r[`AFH_CTRL_STORAGE]),
    .len(rx_len),
    .is_super(),
    .valid(rx_kvalid)
  );

  afh_rate_info u_rx_rate (
    .rate(rx_rate_r),
    .legacy(rx_kind_r <= `AFH_KIND_LEG_LAST),
    .storage(ctrl_r[`AFH_CTRL_STORAGE]),
    .dur(rx_dur)
  );

  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign tx_out_fire = tx_out_valid && tx_out_ready;
  assign rx_in_fire = rx_in_valid && rx_in_ready;
  assign rx_pay_fire = rx_pay_valid && rx_pay_ready;

  // ==========================================================
  // AXI4-Lite write channel: address and data in either order
  always @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AFH_RESP_OKAY;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      ctrl_r <= `AFH_CTRL_RST;
      tx_hdr_r <= `AFH_TX_HDR_RST;
      go_r <= 1'b0;
    end
    else
    begin
      go_r <= 1'b0;
      // Ready only while the slot for that channel is free
      s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      // Both halves present: commit and answer
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `AFH_RESP_OKAY;
        case (aw_addr_r)
          `AFH_OFS_CTRL:
            ctrl_r <= w_strb_r[0] ? w_data_r[1:0] : ctrl_r;
          `AFH_OFS_TX_HDR:
            // Each field lives in one byte lane; bit 7 always reads zero
            tx_hdr_r <= {w_strb_r[1] ? w_data_r[12:8] : tx_hdr_r[12:8], 1'b0,
                         w_strb_r[0] ? w_data_r[6:0] : tx_hdr_r[6:0]};
          `AFH_OFS_TX_GO:
            go_r <= w_strb_r[0] && w_data_r[0];
          `AFH_OFS_STATUS:
            go_r <= 1'b0;
          default:
            s_axi_bresp <= `AFH_RESP_DECERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel: data one cycle after the address
  always @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `AFH_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `AFH_RESP_OKAY;
        case (s_axi_araddr)
          `AFH_OFS_CTRL: s_axi_rdata <= {30'h0, ctrl_r};
          `AFH_OFS_TX_HDR: s_axi_rdata <= {19'h0, tx_hdr_r};
          `AFH_OFS_TX_GO: s_axi_rdata <= {31'h0, status_r[`AFH_ST_BUSY]};
          `AFH_OFS_STATUS: s_axi_rdata <= {27'h0, status_r};
          `AFH_OFS_RX_HDR: s_axi_rdata <= {11'h0, rx_rate_r, 6'h0, rx_slot_r, 1'b0, rx_kind_r};
          `AFH_OFS_RX_DUR: s_axi_rdata <= {16'h0, rx_dur};
          `AFH_OFS_TX_SLOT: s_axi_rdata <= {30'h0, slot_r};
          default:
          begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `AFH_RESP_DECERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Status flags: set by hardware wins over write-one-to-clear
  always @*
  begin
    sticky_clr = 5'h0;
    if (wr_fire && aw_addr_r == `AFH_OFS_STATUS && w_strb_r[0])
      sticky_clr = {w_data_r[4:1], 1'b0};
  end

  always @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      status_r <= 5'h0;
    else
    begin
      status_r[4:1] <= (status_r[4:1] & ~sticky_clr[4:1]) | sticky_set[4:1];
      status_r[`AFH_ST_BUSY] <= (tx_st_r != ST_IDLE) || tx_out_valid;
    end
  end

  // ==========================================================
  // Framer: header one, header two, then the payload
  always @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      tx_st_r <= ST_IDLE;
      tx_rem_r <= 9'h0;
      slot_r <= 2'd0;
      sf_kind_r <= 7'h0;
      sf_rate_r <= 5'h0;
      tx_hdr2_r <= 8'h00;
      tx_super_r <= 1'b0;
      tx_out_data <= 8'h00;
      tx_out_valid <= 1'b0;
      tx_out_last <= 1'b0;
      tx_pay_ready <= 1'b0;
    end
    else
    begin
      case (tx_st_r)
        ST_IDLE:
          // Refuse reserved kinds and misused silence suppression
          if (go_r && tx_kvalid && !(ctrl_r[`AFH_CTRL_SILENCE] &&
              tx_kind > `AFH_KIND_SIL_LAST))
          begin
            tx_out_data <= {1'b0, tx_kind};
            tx_out_valid <= 1'b1;
            tx_out_last <= 1'b0;
            tx_rem_r <= tx_len;
            sf_kind_r <= tx_kind;
            sf_rate_r <= (tx_kind <= `AFH_KIND_LEG_LAST) ? 5'h0 : tx_rate;
            tx_super_r <= tx_super;
            if (ctrl_r[`AFH_CTRL_STORAGE])
              tx_hdr2_r <= {3'b000, (tx_kind <= `AFH_KIND_LEG_LAST) ? 5'h0 : tx_rate};
            else
              tx_hdr2_r <= {(tx_super ? slot_r : 2'd0), 1'b0,
                            (tx_kind <= `AFH_KIND_LEG_LAST) ? 5'h0 : tx_rate};
            tx_st_r <= ST_HDR2;
          end
        ST_HDR2:
          if (tx_out_fire)
          begin
            tx_out_data <= tx_hdr2_r;
            tx_out_last <= (tx_rem_r == 9'h0);
            tx_st_r <= ST_PAY;
          end
        ST_PAY:
          if (tx_out_fire)
          begin
            tx_out_valid <= 1'b0;
            tx_out_last <= 1'b0;
            if (tx_rem_r == 9'h0)
            begin
              tx_st_r <= ST_IDLE;
              // Slot advances inside transport superframes only
              if (!ctrl_r[`AFH_CTRL_STORAGE] && tx_super_r)
                slot_r <= slot_r + 2'd1;
              else
                slot_r <= 2'd0;
            end
            else
              tx_pay_ready <= 1'b1;
          end
          else if (tx_pay_valid && tx_pay_ready)
          begin
            // Payload octets pass unchanged, first bit in the MSB
            tx_out_data <= tx_pay_data;
            tx_out_valid <= 1'b1;
            tx_out_last <= (tx_rem_r == 9'h1);
            tx_rem_r <= tx_rem_r - 9'h1;
            tx_pay_ready <= 1'b0;
          end
        default:
          tx_st_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Parser: header checks, payload forwarding, frame discard
  always @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      rx_st_r <= ST_IDLE;
      rx_kind_r <= 7'h0;
      rx_slot_r <= 2'd0;
      rx_rate_r <= 5'h0;
      rx_bad_r <= 1'b0;
      rx_rem_r <= 9'h0;
      rx_in_ready <= 1'b0;
      rx_pay_data <= 8'h00;
      rx_pay_valid <= 1'b0;
      rx_pay_last <= 1'b0;
    end
    else
    begin
      case (rx_st_r)
        ST_IDLE:
        begin
          rx_in_ready <= 1'b1;
          if (rx_in_fire)
          begin
            rx_kind_r <= rx_kind_now;
            rx_bad_r <= rx_in_data[7];
            rx_st_r <= rx_in_last ? ST_IDLE : ST_HDR2;
          end
        end
        ST_HDR2:
          if (rx_in_fire)
          begin
            rx_slot_r <= ctrl_r[`AFH_CTRL_STORAGE] ? 2'd0 : rx_in_data[7:6];
            // Rate index is ignored for legacy kinds
            rx_rate_r <= (rx_kind_r <= `AFH_KIND_LEG_LAST) ? 5'h0 : rx_in_data[4:0];
            rx_rem_r <= rx_len;
            if (rx_bad_r || !rx_kvalid ||
                (ctrl_r[`AFH_CTRL_STORAGE] && rx_in_data[7:5] != 3'b000))
            begin
              rx_in_ready <= !rx_in_last;
              rx_st_r <= rx_in_last ? ST_IDLE : ST_DROP;
            end
            else if (rx_len == 9'h0)
              rx_st_r <= ST_IDLE;
            else
            begin
              rx_in_ready <= 1'b1;
              rx_st_r <= ST_PAY;
            end
          end
        ST_PAY:
          if (rx_pay_fire)
          begin
            rx_pay_valid <= 1'b0;
            rx_pay_last <= 1'b0;
            rx_in_ready <= (rx_rem_r != 9'h0);
            if (rx_rem_r == 9'h0)
              rx_st_r <= ST_IDLE;
          end
          else if (rx_in_fire)
          begin
            rx_pay_data <= rx_in_data;
            rx_pay_valid <= 1'b1;
            rx_pay_last <= (rx_rem_r == 9'h1);
            rx_rem_r <= rx_rem_r - 9'h1;
            rx_in_ready <= 1'b0;
          end
        ST_DROP:
          // Discard everything up to the frame's last octet
          if (rx_in_fire && rx_in_last)
            rx_st_r <= ST_IDLE;
        default:
          rx_st_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Event sources for the sticky status bits
  always @*
  begin
    sticky_set = 5'h0;
    if (rx_st_r == ST_HDR2 && rx_in_fire)
    begin
      sticky_set[`AFH_ST_ERASED] = rx_bad_r || !rx_kvalid ||
        (ctrl_r[`AFH_CTRL_STORAGE] && rx_in_data[7:5] != 3'b000);
      sticky_set[`AFH_ST_LOST] = (rx_kind_r == `AFH_KIND_LOST);
      sticky_set[`AFH_ST_RXEMPTY] = (rx_kind_r == `AFH_KIND_EMPTY);
    end
    if (tx_st_r == ST_IDLE && go_r)
      sticky_set[`AFH_ST_CFGERR] = !tx_kvalid || (ctrl_r[`AFH_CTRL_SILENCE] &&
        tx_kind > `AFH_KIND_SIL_LAST);
  end
endmodule
`default_nettype wire

// ---- sim/afh_link.sv ----
// Transport side model: stalls one cycle in four, captures octets
`timescale 1ns/1ps
`default_nettype none
module afh_link (
  input wire logic sys_clk,
  input wire logic [7:0] tx_out_data,
  input wire logic tx_out_valid,
  output logic tx_out_ready,
  input wire logic tx_out_last
);
  logic [7:0] got[$]; // Octets of the current unit
  logic [1:0] ph_r = 2'h0; // Stall phase
  int last_at = -1; // Index of the octet marked last
  // Capture each accepted octet
  always @(posedge sys_clk)
  begin
    ph_r <= ph_r + 2'h1;
    if (tx_out_valid && tx_out_ready)
    begin
      if (tx_out_last)
        last_at = got.size();
      got.push_back(tx_out_data);
    end
  end
  assign tx_out_ready = (ph_r != 2'h3);
endmodule
`default_nettype wire

// ---- sim/afh_framer_chk.sv ----
// Port checks of the frame header framer
`timescale 1ns/1ps
`default_nettype none
module afh_framer_chk (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [7:0] tx_out_data,
  input wire logic tx_out_valid,
  input wire logic tx_out_ready,
  input wire logic tx_out_last,
  input wire logic [7:0] rx_in_data,
  input wire logic rx_in_valid,
  input wire logic rx_in_ready,
  input wire logic rx_in_last,
  input wire logic rx_pay_valid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [1:0] pos_r; // Octet position in tx unit, stops at 2
  logic [6:0] kind_r; // Kind of the tx unit
  logic rx_first_r; // Next rx octet opens a frame
  logic drop_r; // Rx frame being discarded
  wire tx_hs = tx_out_valid && tx_out_ready;
  wire rx_hs = rx_in_valid && rx_in_ready;
  // Track unit positions
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pos_r <= 2'h0;
      kind_r <= 7'h0;
      rx_first_r <= 1'b1;
      drop_r <= 1'b0;
    end
    else
    begin
      if (tx_hs)
        pos_r <= tx_out_last ? 2'h0 : (pos_r == 2'h2 ? 2'h2 : pos_r + 2'h1);
      if (tx_hs && pos_r == 2'h0)
        kind_r <= tx_out_data[6:0];
      if (rx_hs)
        rx_first_r <= rx_in_last;
      if (rx_hs)
        drop_r <= !rx_in_last && (drop_r || (rx_first_r && rx_in_data[7]));
    end
  end
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_resp;
    ##2 s_axi_bvalid;
  endsequence
  a_wr_resp_time: assert property (s_wr_both |-> s_resp)
    else $error("write answer late");
  a_rd_resp_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_tx_hold: assert property (tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(tx_out_data) && $stable(tx_out_last))
    else $error("tx octet dropped");
  a_hdr1_msb: assert property (tx_out_valid && pos_r == 2'h0 |-> !tx_out_data[7])
    else $error("header msb set");
  a_hdr1_not_last: assert property (tx_out_valid && pos_r == 2'h0 |-> !tx_out_last)
    else $error("unit ends at header one");
  a_hdr2_bit_six: assert property (tx_out_valid && pos_r == 2'h1 |-> !tx_out_data[5])
    else $error("header two bit six set");
  a_legacy_rate: assert property (tx_out_valid && pos_r == 2'h1 && kind_r <= 7'h0d |-> tx_out_data[4:0] == 5'h0)
    else $error("legacy rate not zero");
  a_erased_quiet: assert property (drop_r |-> !rx_pay_valid)
    else $error("erased frame forwarded");
endmodule
bind afh_framer afh_framer_chk u_chk (.*);
`default_nettype wire

// ---- sim/audio_frame_header_framer_tb.sv ----
// Self-checking bench of the frame header framer
`timescale 1ns/1ps
`default_nettype none
module audio_frame_header_framer_tb;
  logic sys_clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic tx_pay_valid, tx_pay_ready, tx_out_valid, tx_out_ready, tx_out_last;
  logic rx_in_valid, rx_in_ready, rx_in_last, rx_pay_valid, rx_pay_ready, rx_pay_last;
  logic [7:0] s_axi_awaddr, s_axi_araddr, tx_out_data, rx_in_data, rx_pay_data;
  logic [7:0] tx_pay_data = 8'h00; // Counting payload source
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  int mismatches = 0;
  int compares = 0;
  int rxn = 0; // Parsed payload octets
  int rxl = 0; // Count at the octet marked last
  afh_framer DUT (.*);
  afh_link P (.*);
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Codec side: counting payload source and parsed octet counter
  always @(posedge sys_clk)
  begin
    if (tx_pay_valid && tx_pay_ready)
      tx_pay_data <= tx_pay_data + 8'h01;
    if (rx_pay_valid && rx_pay_ready)
    begin
      rxn = rxn + 1;
      if (rx_pay_last)
        rxl = rxn;
    end
  end
  task automatic fail(input string m);
    mismatches++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp)
      fail($sformatf("%s got %h exp %h", m, got, exp));
  endtask
  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    repeat (100)
    begin
      @(posedge sys_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        resp = s_axi_bresp;
        return;
      end
    end
    fail("write hang");
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    repeat (100)
    begin
      @(posedge sys_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        return;
      end
    end
    fail("read hang");
  endtask
  // Start one unit and judge every octet the link took
  task automatic tx_unit(input logic [31:0] hdr, input int n, input logic [7:0] h1, h2);
    logic [7:0] b;
    b = tx_pay_data;
    P.got.delete();
    P.last_at = -1;
    wr(8'h04, hdr);
    wr(8'h08, 32'h1);
    for (int i = 0; i < 3000 && P.got.size() < n; i++)
      @(posedge sys_clk);
    repeat (12) @(posedge sys_clk);
    chk(P.got.size(), n, "unit size");
    chk(P.last_at, n - 1, "last");
    chk(P.got[0], h1, "hdr1");
    chk(P.got[1], h2, "hdr2");
    for (int i = 2; i < n; i++)
      chk(P.got[i], 8'(b + i - 2), "payload");
  endtask
  task automatic put(input logic [7:0] d, input logic l);
    rx_in_data <= d;
    rx_in_last <= l;
    rx_in_valid <= 1'b1;
    repeat (100)
    begin
      @(posedge sys_clk);
      if (rx_in_ready)
        return;
    end
    fail("rx hang");
  endtask
  task automatic rx_frame(input logic [7:0] h1, h2, input int n);
    put(h1, 1'b0);
    put(h2, n == 0);
    for (int i = 0; i < n; i++)
      put(8'(i), i == n - 1);
    rx_in_valid <= 1'b0;
    repeat (20) @(posedge sys_clk);
  endtask
  task automatic t_regs;
    rd(8'h00);
    chk(rdat, 32'h0, "ctrl reset");
    rd(8'h0c);
    chk(rdat, 32'h0, "status reset");
    rd(8'h1c);
    chk(resp, 32'h3, "rd unmapped");
    wr(8'h1c, 32'h1);
    chk(resp, 32'h3, "wr unmapped");
    $display("regs done");
  endtask
  task automatic t_tx;
    wr(8'h00, 32'h1);
    tx_unit(32'h30a, 2, 8'h0a, 8'h00);
    tx_unit(32'h310, 106, 8'h10, 8'h03);
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h9);
    P.got.delete();
    wr(8'h08, 32'h1);
    repeat (20) @(posedge sys_clk);
    chk(P.got.size(), 0, "refused");
    rd(8'h0c);
    chk(rdat, 32'h8, "cfg error");
    wr(8'h0c, 32'h8);
    tx_unit(32'h8, 2, 8'h08, 8'h00);
    wr(8'h00, 32'h0);
    tx_unit(32'h81a, 37, 8'h1a, 8'h08);
    tx_unit(32'h510, 37, 8'h1a, 8'h48);
    $display("framer done");
  endtask
  task automatic t_rx;
    rx_frame(8'h1a, 8'h48, 35);
    chk(rxn, 35, "rx payload");
    chk(rxl, 35, "rx last");
    rd(8'h10);
    chk(rdat, 32'h8011a, "rx header");
    rd(8'h14);
    chk(rdat, 32'h7d0, "rx duration");
    rx_frame(8'h80, 8'h00, 1);
    rx_frame(8'h30, 8'h00, 1);
    rx_frame(8'h0e, 8'h00, 0);
    rx_frame(8'h0f, 8'h08, 0);
    chk(rxn, 35, "dropped");
    rd(8'h0c);
    chk(rdat, 32'h16, "rx flags");
    $display("parser done");
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #(25 * 30000);
    fail("timeout");
    finish_test();
  end
  initial
  begin
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, tx_pay_valid, rx_in_valid} = 6'h0;
    {s_axi_bready, s_axi_rready, rx_pay_ready, rx_in_last} = 4'he;
    {s_axi_awaddr, s_axi_araddr, rx_in_data} = 24'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    tx_pay_valid <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    finish_test();
  end
endmodule
`default_nettype wire
